//--- rtl/tcc_channel.sv
`timescale 1ns/1ps
module tcc_channel (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rstN,
  // shared counter
  input wire logic [tcc_pkg::CNT_W-1:0] cnt,
  input wire logic reverse,
  input wire logic cpwm,
  input wire logic down,
  // channel configuration
  input wire logic chScWr,
  input wire logic msHi,
  input wire logic msLo,
  input wire logic elsHi,
  input wire logic elsLo,
  input wire logic chIe,
  // byte access
  input wire logic valWrHi,
  input wire logic valWrLo,
  input wire logic [tcc_pkg::BYTE_W-1:0] wrData,
  input wire logic valRdHi,
  input wire logic valRdLo,
  input wire logic flagRd,
  input wire logic flagClr,
  output logic [tcc_pkg::BYTE_W-1:0] rdData,
  // status
  output logic chFlag,
  output logic chIrq,
  // channel pin
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOeB
);

  localparam int W = tcc_pkg::CNT_W;
  localparam int B = tcc_pkg::BYTE_W;

  typedef struct packed {
    logic [W-1:0] val;
    logic [W-1:0] pend;
    logic [W-1:0] snap;
    logic [B-1:0] rd;
    logic gotHi;
    logic gotLo;
    logic held;
    logic wantLo;
    logic flag;
    logic armed;
    logic out;
    logic s1;
    logic s2;
    logic prev;
  } tcc_chan_s;

  tcc_chan_s state_ff;
  tcc_chan_s nxt_state;
  tcc_pkg::tcc_mode_e mode;
  logic hit;
  logic pwmHigh;
  logic [W-1:0] src;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    src = state_ff.held ? state_ff.snap : state_ff.val;
    if (cpwm)
      mode = tcc_pkg::MODE_CPWM;
    else if (msHi)
      mode = tcc_pkg::MODE_EPWM;
    else if (msLo)
      mode = tcc_pkg::MODE_COMPARE;
    else
      mode = tcc_pkg::MODE_CAPTURE;
    nxt_state.s1 = pinIn;
    nxt_state.s2 = state_ff.s1;
    nxt_state.prev = state_ff.s2;
    case (mode)
      tcc_pkg::MODE_CAPTURE:
        hit = (elsLo && state_ff.s2 && !state_ff.prev)
          || (elsHi && !state_ff.s2 && state_ff.prev);
      default:
        hit = (cnt == state_ff.val);
    endcase
    // center mode: the down-count match raises the pulse, so width is twice the value
    if (cpwm)
      pwmHigh = ((cnt < state_ff.val) || (down && cnt == state_ff.val))
        && state_ff.val != tcc_pkg::CNT_ZERO && !state_ff.val[W-1];
    else
      pwmHigh = cnt < state_ff.val;
    // byte writes land in the pending buffer
    if (valWrHi)
    begin
      nxt_state.pend[W-1:B] = wrData;
      nxt_state.gotHi = 1'b1;
    end
    if (valWrLo)
    begin
      nxt_state.pend[B-1:0] = wrData;
      nxt_state.gotLo = 1'b1;
    end
    if (nxt_state.gotHi && nxt_state.gotLo && (mode == tcc_pkg::MODE_COMPARE
        || mode == tcc_pkg::MODE_CAPTURE
        || (mode == tcc_pkg::MODE_EPWM && cnt == tcc_pkg::CNT_ZERO)
        || (mode == tcc_pkg::MODE_CPWM && reverse)))
    begin
      nxt_state.val = nxt_state.pend;
      nxt_state.gotHi = 1'b0;
      nxt_state.gotLo = 1'b0;
    end
    // reads: capture mode freezes both bytes until the other one is read
    if (valRdHi || valRdLo)
    begin
      if (mode == tcc_pkg::MODE_CAPTURE)
      begin
        nxt_state.rd = valRdHi ? src[W-1:B] : src[B-1:0];
        if (!state_ff.held)
        begin
          nxt_state.snap = state_ff.val;
          nxt_state.held = 1'b1;
          nxt_state.wantLo = valRdHi;
        end
        else if (valRdHi != state_ff.wantLo)
          nxt_state.held = 1'b0;
      end
      else
        nxt_state.rd = valRdHi ? state_ff.val[W-1:B] : state_ff.val[B-1:0];
    end
    if (chScWr)
    begin
      nxt_state.gotHi = 1'b0;
      nxt_state.gotLo = 1'b0;
      nxt_state.held = 1'b0;
    end
    if (mode == tcc_pkg::MODE_CAPTURE && hit)
      nxt_state.val = cnt;
    case (mode)
      tcc_pkg::MODE_COMPARE:
        if (hit)
        begin
          case ({elsHi, elsLo})
            tcc_pkg::OC_TOGGLE: nxt_state.out = !state_ff.out;
            tcc_pkg::OC_CLEAR: nxt_state.out = 1'b0;
            tcc_pkg::OC_SET: nxt_state.out = 1'b1;
            default: nxt_state.out = state_ff.out;
          endcase
        end
      tcc_pkg::MODE_EPWM, tcc_pkg::MODE_CPWM:
        nxt_state.out = pwmHigh ^ elsLo;
      default:
        nxt_state.out = state_ff.out;
    endcase
    // two-step clear; a new event in between keeps the flag
    if (flagRd && state_ff.flag)
      nxt_state.armed = 1'b1;
    if (flagClr && state_ff.armed)
    begin
      nxt_state.flag = 1'b0;
      nxt_state.armed = 1'b0;
    end
    if (hit)
    begin
      nxt_state.flag = 1'b1;
      nxt_state.armed = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign rdData = state_ff.rd;
  assign chFlag = state_ff.flag;
  assign chIrq = state_ff.flag && chIe;
  assign pinOut = state_ff.out;
  assign pinOeB = (mode == tcc_pkg::MODE_CAPTURE) || ({elsHi, elsLo} == tcc_pkg::ELS_OFF);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  cap_value_a:
    assert property (mode == tcc_pkg::MODE_CAPTURE && hit |=> state_ff.val == $past(cnt))
      else $error("capture did not store counter");
  event_flag_a:
    assert property (hit ##1 !hit [*2] |-> state_ff.flag)
      else $error("channel event did not set flag");
  cmp_load_a:
    assert property (mode == tcc_pkg::MODE_COMPARE && state_ff.gotHi && valWrLo
      && !valWrHi && !chScWr && !hit |=> state_ff.val == {$past(state_ff.pend[W-1:B]),
      $past(wrData)})
      else $error("compare value not loaded after both bytes");
  epwm_hold_a:
    assert property (mode == tcc_pkg::MODE_EPWM && cnt != tcc_pkg::CNT_ZERO
      |=> $stable(state_ff.val))
      else $error("pwm value changed mid period");
  epwm_zero_a:
    assert property (mode == tcc_pkg::MODE_EPWM && state_ff.val == tcc_pkg::CNT_ZERO
      |=> pinOut == $past(elsLo))
      else $error("zero duty produced a pulse");
  cpwm_neg_a:
    assert property (cpwm && state_ff.val[W-1] |=> pinOut == $past(elsLo))
      else $error("negative value produced a pulse");
  oc_toggle_a:
    assert property (mode == tcc_pkg::MODE_COMPARE && hit
      && {elsHi, elsLo} == tcc_pkg::OC_TOGGLE |=> pinOut != $past(pinOut))
      else $error("compare toggle missed");

endmodule : tcc_channel

//--- rtl/tcc_pkg.sv
package tcc_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int NUM_CH = 2;

  // ------------------------------------------------------------
  // counter values
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] RST_VAL = 16'h0000;

  // ------------------------------------------------------------
  // edge select and compare action codes {edgeHi, edgeLo}
  // ------------------------------------------------------------
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] OC_TOGGLE = 2'h1;
  localparam logic [1:0] OC_CLEAR = 2'h2;
  localparam logic [1:0] OC_SET = 2'h3;

  // ------------------------------------------------------------
  // channel modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {MODE_CAPTURE, MODE_COMPARE, MODE_EPWM, MODE_CPWM} tcc_mode_e;

endpackage : tcc_pkg

//--- rtl/tcc_timer.sv
`timescale 1ns/1ps
module tcc_timer #(
  parameter int NUM_CH = tcc_pkg::NUM_CH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // timer control
  input wire logic cpwm,
  input wire logic overflow_interrupt_enable,
  input wire logic tscWr,
  input wire logic cntWr,
  input wire logic modWrHi,
  input wire logic modWrLo,
  input wire logic [tcc_pkg::BYTE_W-1:0] wrData,
  input wire logic ovfRd,
  input wire logic ovfClr,
  // timer status
  output logic [tcc_pkg::CNT_W-1:0] count,
  output logic [tcc_pkg::CNT_W-1:0] modulus,
  output logic countDown,
  output logic overflowFlag,
  output logic ovfIrq,
  // channel configuration
  input wire logic [NUM_CH-1:0] chScWr,
  input wire logic [NUM_CH-1:0] chMsHi,
  input wire logic [NUM_CH-1:0] chMsLo,
  input wire logic [NUM_CH-1:0] chElsHi,
  input wire logic [NUM_CH-1:0] chElsLo,
  input wire logic [NUM_CH-1:0] chIe,
  // channel byte access
  input wire logic [NUM_CH-1:0] chValWrHi,
  input wire logic [NUM_CH-1:0] chValWrLo,
  input wire logic [NUM_CH-1:0] chValRdHi,
  input wire logic [NUM_CH-1:0] chValRdLo,
  input wire logic [NUM_CH-1:0] chFlagRd,
  input wire logic [NUM_CH-1:0] chFlagClr,
  output logic [NUM_CH-1:0][tcc_pkg::BYTE_W-1:0] chRdData,
  // channel status
  output logic [NUM_CH-1:0] chFlag,
  output logic [NUM_CH-1:0] chIrq,
  // channel pins
  input wire logic [NUM_CH-1:0] chPinIn,
  output logic [NUM_CH-1:0] chPinOut,
  output logic [NUM_CH-1:0] chPinOeB
);

  localparam int W = tcc_pkg::CNT_W;
  localparam int B = tcc_pkg::BYTE_W;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] mod;
    logic [W-1:0] pend;
    logic gotHi;
    logic gotLo;
    logic down;
    logic ovf;
    logic armed;
  } tcc_tmr_s;

  logic [1:0] rstSync_ff;
  logic rstN;
  tcc_tmr_s state_ff;
  tcc_tmr_s nxt_state;
  logic [W-1:0] term;
  logic wrap;
  logic reverse;
  logic ovfEvt;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rstSync_ff <= 2'h0;
    else
      rstSync_ff <= {rstSync_ff[0], 1'b1};
  end

  assign rstN = rstSync_ff[1];

  // ------------------------------------------------------------
  // counter, modulus buffer and overflow flag
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    wrap = 1'b0;
    reverse = 1'b0;
    // in up-count mode a zero modulus means the full 16-bit range
    term = (state_ff.mod == tcc_pkg::CNT_ZERO) ? tcc_pkg::CNT_MAX : state_ff.mod;
    if (cpwm)
    begin
      if (!state_ff.down)
      begin
        // a zero modulus reverses at zero and wraps downward: undefined use
        if (state_ff.cnt == state_ff.mod)
        begin
          nxt_state.down = 1'b1;
          nxt_state.cnt = state_ff.cnt - tcc_pkg::CNT_ONE;
          reverse = 1'b1;
        end
        else
          nxt_state.cnt = state_ff.cnt + tcc_pkg::CNT_ONE;
      end
      else if (state_ff.cnt == tcc_pkg::CNT_ZERO)
      begin
        // both ends are full-length counts, so leave zero going up
        nxt_state.down = 1'b0;
        nxt_state.cnt = tcc_pkg::CNT_ONE;
      end
      else
        nxt_state.cnt = state_ff.cnt - tcc_pkg::CNT_ONE;
    end
    else
    begin
      nxt_state.down = 1'b0;
      if (state_ff.cnt == term)
      begin
        nxt_state.cnt = tcc_pkg::CNT_ZERO;
        wrap = 1'b1;
      end
      else
        nxt_state.cnt = state_ff.cnt + tcc_pkg::CNT_ONE;
    end
    if (cntWr)
    begin
      nxt_state.cnt = tcc_pkg::CNT_ZERO;
      nxt_state.down = 1'b0;
    end
    ovfEvt = (wrap || reverse) && !cntWr;

    // modulus bytes: coherent pair, in center mode only at reversal
    if (modWrHi)
    begin
      nxt_state.pend[W-1:B] = wrData;
      nxt_state.gotHi = 1'b1;
    end
    if (modWrLo)
    begin
      nxt_state.pend[B-1:0] = wrData;
      nxt_state.gotLo = 1'b1;
    end
    if (nxt_state.gotHi && nxt_state.gotLo && (!cpwm || reverse))
    begin
      nxt_state.mod = nxt_state.pend;
      nxt_state.gotHi = 1'b0;
      nxt_state.gotLo = 1'b0;
    end
    if (tscWr)
    begin
      nxt_state.gotHi = 1'b0;
      nxt_state.gotLo = 1'b0;
    end

    // read-while-set arms the clear; an event in between wins
    if (ovfRd && state_ff.ovf)
      nxt_state.armed = 1'b1;
    if (ovfClr && state_ff.armed)
    begin
      nxt_state.ovf = 1'b0;
      nxt_state.armed = 1'b0;
    end
    if (ovfEvt)
    begin
      nxt_state.ovf = 1'b1;
      nxt_state.armed = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_ff <= '0;
      state_ff.cnt <= tcc_pkg::RST_VAL;
      state_ff.mod <= tcc_pkg::RST_VAL;
    end
    else
      state_ff <= nxt_state;
  end

  assign count = state_ff.cnt;
  assign modulus = state_ff.mod;
  assign countDown = state_ff.down;
  assign overflowFlag = state_ff.ovf;
  // level request: stays up for as long as flag and enable are both set
  assign ovfIrq = state_ff.ovf && overflow_interrupt_enable;

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    tcc_channel u_ch (
      .clk(clk),
      .rstN(rstN),
      .cnt(state_ff.cnt),
      .reverse(reverse),
      .cpwm(cpwm),
      .down(state_ff.down),
      .chScWr(chScWr[i]),
      .msHi(chMsHi[i]),
      .msLo(chMsLo[i]),
      .elsHi(chElsHi[i]),
      .elsLo(chElsLo[i]),
      .chIe(chIe[i]),
      .valWrHi(chValWrHi[i]),
      .valWrLo(chValWrLo[i]),
      .wrData(wrData),
      .valRdHi(chValRdHi[i]),
      .valRdLo(chValRdLo[i]),
      .flagRd(chFlagRd[i]),
      .flagClr(chFlagClr[i]),
      .rdData(chRdData[i]),
      .chFlag(chFlag[i]),
      .chIrq(chIrq[i]),
      .pinIn(chPinIn[i]),
      .pinOut(chPinOut[i]),
      .pinOeB(chPinOeB[i])
    );
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  ovf_wrap_a:
    assert property (!cpwm && !cntWr && state_ff.cnt == term
      |=> state_ff.ovf && state_ff.cnt == tcc_pkg::CNT_ZERO)
      else $error("up-count wrap did not set overflow");

  free_run_a:
    assert property (!cpwm && !cntWr && state_ff.mod == tcc_pkg::CNT_ZERO
      && state_ff.cnt == tcc_pkg::CNT_MAX - tcc_pkg::CNT_ONE
      |=> state_ff.cnt == tcc_pkg::CNT_MAX)
      else $error("zero modulus stopped short of full range");

  cpwm_rev_a:
    assert property (cpwm && !cntWr && !state_ff.down && state_ff.cnt == state_ff.mod
      |=> state_ff.down && state_ff.ovf)
      else $error("no reversal or overflow at terminal count");

  cpwm_bottom_a:
    assert property (cpwm && !cntWr && state_ff.down && state_ff.cnt == tcc_pkg::CNT_ONE
      ##1 cpwm && !cntWr |=> !state_ff.down && state_ff.cnt == tcc_pkg::CNT_ONE)
      else $error("down count did not turn at zero");

  mod_hold_a:
    assert property (cpwm && !reverse |=> state_ff.mod == $past(state_ff.mod))
      else $error("modulus changed away from reversal");

  mod_discard_a:
    assert property (tscWr ##1 cpwm && !reverse && !modWrHi && !modWrLo
      |=> !state_ff.gotHi && !state_ff.gotLo && $stable(state_ff.mod))
      else $error("timer control write kept pending modulus");

  flag_keep_a:
    assert property (state_ff.ovf && ovfClr && !state_ff.armed |=> state_ff.ovf)
      else $error("overflow flag cleared without prior read");

  flag_clear_a:
    assert property (state_ff.armed && ovfClr && !ovfEvt |=> !state_ff.ovf)
      else $error("armed clear did not clear overflow flag");

  irq_level_a:
    assert property (state_ff.ovf && overflow_interrupt_enable && !ovfClr ##1 overflow_interrupt_enable |-> ovfIrq)
      else $error("overflow request dropped while flag set");

endmodule : tcc_timer

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  localparam int MH = 0, ML = 1, VH = 2, VL = 3, TSC = 4, CSC = 5, CW = 6;
  localparam int ORD = 7, OCL = 8, FRD = 9, FCL = 10, RH = 11, RL = 12;
  logic clk = 1'h0, rst_b = 1'h0, cpwm = 1'h0, overflow_interrupt_enable = 1'h0, tscWr = 1'h0, cntWr = 1'h0;
  logic modWrHi = 1'h0, modWrLo = 1'h0, ovfRd = 1'h0, ovfClr = 1'h0;
  logic [7:0] wrData = 8'h00;
  logic [1:0] chScWr = 2'h0, chMsHi = 2'h0, chMsLo = 2'h0, chElsHi = 2'h0, chElsLo = 2'h0;
  logic [1:0] chIe = 2'h3, chValWrHi = 2'h0, chValWrLo = 2'h0, chValRdHi = 2'h0;
  logic [1:0] chValRdLo = 2'h0, chFlagRd = 2'h0, chFlagClr = 2'h0, srcLevel = 2'h0;
  logic [15:0] count, modulus, refCnt = 16'h0000;
  logic countDown, overflowFlag, ovfIrq;
  logic [1:0][7:0] chRdData;
  logic [1:0] chFlag, chIrq, chPinIn, chPinOut, chPinOeB, wireLevel;
  int checks = 0;
  int miscompares = 0;

  always #12.5 clk = ~clk;
  // counter reference for free running up mode
  always @(posedge clk) refCnt <= cntWr ? 16'h0000 : refCnt + 16'h0001;

  tcc_timer DUT (.clk, .rst_b, .cpwm, .overflow_interrupt_enable, .tscWr, .cntWr, .modWrHi, .modWrLo, .wrData,
    .ovfRd, .ovfClr, .count, .modulus, .countDown, .overflowFlag, .ovfIrq, .chScWr, .chMsHi,
    .chMsLo, .chElsHi, .chElsLo, .chIe, .chValWrHi, .chValWrLo, .chValRdHi, .chValRdLo,
    .chFlagRd, .chFlagClr, .chRdData, .chFlag, .chIrq, .chPinIn, .chPinOut, .chPinOeB);

  tcc_pin_model pins (.pinOut(chPinOut), .pinOeB(chPinOeB), .srcLevel(srcLevel),
    .pinIn(chPinIn), .wireLevel(wireLevel));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse(input int k, input int ch, input logic [7:0] d);
    @(posedge clk);
    wrData <= d;
    case (k)
      MH: modWrHi <= 1'h1;
      ML: modWrLo <= 1'h1;
      VH: chValWrHi[ch] <= 1'h1;
      VL: chValWrLo[ch] <= 1'h1;
      TSC: tscWr <= 1'h1;
      CSC: chScWr[ch] <= 1'h1;
      CW: cntWr <= 1'h1;
      ORD: ovfRd <= 1'h1;
      OCL: ovfClr <= 1'h1;
      FRD: chFlagRd[ch] <= 1'h1;
      FCL: chFlagClr[ch] <= 1'h1;
      RH: chValRdHi[ch] <= 1'h1;
      default: chValRdLo[ch] <= 1'h1;
    endcase
    @(posedge clk);
    {modWrHi, modWrLo, tscWr, cntWr, ovfRd, ovfClr} <= 6'h00;
    {chValWrHi, chValWrLo, chScWr, chFlagRd, chFlagClr, chValRdHi, chValRdLo} <= 14'h0000;
  endtask : pulse

  task automatic wr16(input int k, input int ch, input logic [15:0] v);
    pulse(k, ch, v[15:8]);
    pulse(k + 1, ch, v[7:0]);
  endtask : wr16

  task automatic rd(input int ch, input int k, output logic [7:0] d);
    pulse(k, ch, 8'h00);
    #1;
    d = chRdData[ch];
  endtask : rd

  task automatic measure(input int ch, output logic [15:0] hi, output logic [15:0] z,
    output logic [15:0] dn);
    hi = 16'h0000;
    z = 16'h0000;
    dn = 16'h0000;
    repeat (8)
    begin
      @(posedge clk);
      #1;
      hi += chPinOut[ch];
      z += (count === 16'h0000);
      dn += (countDown === 1'h1);
    end
  endtask : measure

  task automatic pwm(input logic [15:0] val, input logic pol, input logic [15:0] exp,
    input int first);
    logic [15:0] hi, z, dn;
    @(posedge clk);
    chElsHi <= 2'h3;
    chElsLo <= {pol, pol};
    for (int ch = first; ch < 2; ch++)
      wr16(VH, ch, val);
    repeat (30) @(posedge clk);
    for (int ch = first; ch < 2; ch++)
    begin
      measure(ch, hi, z, dn);
      chk(hi, exp);
      if (first == 0)
      begin
        chk(z, 16'h0001);
        chk(dn, 16'h0004);
      end
    end
  endtask : pwm

  task automatic act(input logic [1:0] code, input logic pin);
    @(posedge clk);
    {chElsHi[1], chElsLo[1]} <= code;
    for (int i = 0; i < 12; i++)
    begin
      @(posedge clk);
      #1;
      if (count === 16'h0003)
        break;
    end
    @(posedge clk);
    #1;
    chk({chFlag[1], chPinOut[1], chPinOeB[1], wireLevel[1]}, {1'h1, pin, 1'h0, pin});
  endtask : act

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_counter;
    pulse(MH, 0, 8'h00);
    pulse(TSC, 0, 8'h00);
    pulse(ML, 0, 8'h05);
    #1;
    chk(modulus, 16'h0000);
    pulse(MH, 0, 8'h00);
    pulse(CW, 0, 8'h00);
    #1;
    chk(modulus, 16'h0005);
    repeat (5) @(posedge clk);
    #1;
    chk({count, overflowFlag}, {16'h0005, 1'h0});
    @(posedge clk);
    #1;
    chk({count, overflowFlag, ovfIrq}, {16'h0000, 2'h3});
    @(posedge clk);
    overflow_interrupt_enable <= 1'h0;
    @(posedge clk);
    #1;
    chk({overflowFlag, ovfIrq}, 2'h2);
    @(posedge clk);
    overflow_interrupt_enable <= 1'h1;
    wr16(MH, 0, 16'h0000);
    pulse(OCL, 0, 8'h00);
    #1;
    chk(overflowFlag, 1'h1);
    pulse(ORD, 0, 8'h00);
    pulse(OCL, 0, 8'h00);
    #1;
    chk({overflowFlag, ovfIrq}, 2'h0);
    pulse(CW, 0, 8'h00);
    repeat (10) @(posedge clk);
    #1;
    chk(count, 16'h000A);
    $display("test counter done");
  endtask : test_counter

  task automatic test_capture;
    logic [15:0] a, b;
    logic [7:0] d;
    pulse(CSC, 0, 8'h00);
    @(posedge clk);
    {chElsHi[0], chElsLo[0]} <= 2'h3;
    srcLevel[0] <= 1'h1;
    // two sync flops, then the third cycle's count is stamped
    a = refCnt + 16'h0003;
    repeat (6) @(posedge clk);
    #1;
    chk({chFlag[0], chIrq[0]}, 2'h3);
    @(posedge clk);
    chIe[0] <= 1'h0;
    @(posedge clk);
    #1;
    chk({chFlag[0], chIrq[0]}, 2'h2);
    @(posedge clk);
    chIe[0] <= 1'h1;
    rd(0, RH, d);
    chk(d, a[15:8]);
    @(posedge clk);
    srcLevel[0] <= 1'h0;
    b = refCnt + 16'h0003;
    repeat (6) @(posedge clk);
    rd(0, RL, d);
    chk(d, a[7:0]);
    rd(0, RH, d);
    chk(d, b[15:8]);
    rd(0, RL, d);
    chk(d, b[7:0]);
    pulse(FRD, 0, 8'h00);
    pulse(FCL, 0, 8'h00);
    #1;
    chk(chFlag[0], 1'h0);
    $display("test capture done");
  endtask : test_capture

  task automatic test_compare;
    logic [7:0] d;
    wr16(MH, 0, 16'h0009);
    pulse(CW, 0, 8'h00);
    @(posedge clk);
    chMsLo[1] <= 1'h1;
    wr16(VH, 1, 16'h0005);
    pulse(VH, 1, 8'h00);
    pulse(CSC, 1, 8'h00);
    pulse(VL, 1, 8'h03);
    rd(1, RL, d);
    chk(d, 8'h05);
    pulse(VH, 1, 8'h00);
    rd(1, RL, d);
    chk(d, 8'h03);
    act(2'h3, 1'h1);
    act(2'h2, 1'h0);
    act(2'h1, 1'h1);
    act(2'h1, 1'h0);
    $display("test compare done");
  endtask : test_compare

  task automatic test_pwm;
    wr16(MH, 0, 16'h0007);
    pulse(CW, 0, 8'h00);
    @(posedge clk);
    chMsHi[1] <= 1'h1;
    pwm(16'h0003, 1'h0, 16'h0003, 1);
    pwm(16'h0003, 1'h1, 16'h0005, 1);
    pwm(16'h0000, 1'h0, 16'h0000, 1);
    pwm(16'h0009, 1'h0, 16'h0008, 1);
    // capture and compare mode bits must not matter here
    @(posedge clk);
    {chMsHi, chMsLo} <= 4'h2;
    cpwm <= 1'h1;
    // a stray high byte dropped by the timer control write
    pulse(MH, 0, 8'h01);
    pulse(TSC, 0, 8'h00);
    wr16(MH, 0, 16'h0004);
    pwm(16'h0002, 1'h0, 16'h0004, 0);
    pwm(16'h0001, 1'h1, 16'h0006, 0);
    pwm(16'h0000, 1'h0, 16'h0000, 0);
    pwm(16'h8000, 1'h0, 16'h0000, 0);
    pwm(16'h0005, 1'h0, 16'h0008, 0);
    $display("test pwm done");
  endtask : test_pwm

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end

  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    chk(count, 16'h0000);
    chk({overflowFlag, ovfIrq, chFlag, chIrq, chPinOut}, 16'h0000);
    chk(chRdData, 16'h0000);
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    overflow_interrupt_enable <= 1'h1;
    repeat (4) @(posedge clk);
    test_counter;
    test_capture;
    test_compare;
    test_pwm;
    finish_test;
  end
endmodule : tb_top

//--- tb/tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model (
  // timer side of the pins
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOeB,
  // external event source
  input wire logic [1:0] srcLevel,
  // resolved pins
  output logic [1:0] pinIn,
  output logic [1:0] wireLevel
);
  // ------------------------------------------------------------
  // pin resolution
  // ------------------------------------------------------------
  // source reaches the pin only while the timer has let it go
  assign wireLevel = (pinOeB & srcLevel) | (~pinOeB & pinOut);
  assign pinIn = wireLevel;
endmodule : tcc_pin_model
